/* core/dplw_params.svh */
// Purpose: constants for the debug port lock window block
// Assumes: one clock at 100 MHz
// Notes: values are hardware figures, names are local
`ifndef DPLW_PARAMS_SVH
`define DPLW_PARAMS_SVH
`define DPLW_WINDOW_CYCLES 7'h40
`define DPLW_KEY 16'ha5a5
`define DPLW_CNT_W 7
`define DPLW_CNT_ZERO 7'h00
`define DPLW_CNT_ONE 7'h01
`define DPLW_RDATA_RST 16'h0001
`define DPLW_RDATA_PAD 15'h0000
`define DPLW_CALIB_RST 16'h0000
`endif

/* core/dplw_pkg.sv */
// Purpose: types for the debug port lock window block
// Assumes: nothing beyond the params header
// Notes: lock states of the window controller
`default_nettype none
package dplw_pkg;
    typedef enum logic [1:0] {
        DPLW_OPEN,
        DPLW_LOCKED,
        DPLW_ENABLED
    } dplw_state_t;
    typedef logic [15:0] dplw_word_t;
endpackage
`default_nettype wire

/* core/dplw_calib_hold.sv */
// Purpose: calibration register store kept across warm resets
// Assumes: power_cycle_i marks a true loss of supply
// Notes: only a power cycle clears the contents
`include "dplw_params.svh"
`default_nettype none
module dplw_calib_hold (
    // clock and power loss
    input wire logic clk_i,
    input wire logic power_cycle_i,
    // load port
    input wire logic load_i,
    input wire dplw_pkg::dplw_word_t load_data_i,
    // contents
    output logic [15:0] calib_o,
    output logic valid_o
);
    import dplw_pkg::*;
    // warm resets do not reach these flops on purpose
    always_ff @(posedge clk_i or posedge power_cycle_i) begin
        if (power_cycle_i) begin
            calib_o <= `DPLW_CALIB_RST;
            valid_o <= 1'b0;
        end else if (load_i) begin
            calib_o <= load_data_i;
            valid_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* core/dplw_top.sv */
// Purpose: debug port lock window after brownout or power-on reset
// Assumes: reset_i is brownout or power-on reset; clk_i is main clock
// Notes: software writes only reach the lock through lock_wr_i
//
// How it works
// - disable key counts only inside 64 cycles
// - writes after the window are ignored
// - reads show lock state, never change it
// - debug held disabled while window open
// - no key or low power by window end enables debug
// - key 0xa5a5 locks the debug port
// - low power inside window locks debug
// - startup routine runs after every reset
// - calibration kept except over power cycle
`include "dplw_params.svh"
`default_nettype none
module dplw_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic power_cycle_i,
    input wire logic power_up_clear_i,
    // debug lock register port
    input wire logic lock_wr_i,
    input wire dplw_pkg::dplw_word_t lock_wdata_i,
    input wire logic lock_rd_i,
    output logic [15:0] lock_rdata_o,
    // low power request
    input wire logic low_power_i,
    // brownout flag clear from firmware
    input wire logic brownout_reset_flag_clr_i,
    output logic brownout_reset_flag_o,
    // calibration load
    input wire logic calib_load_i,
    input wire dplw_pkg::dplw_word_t calib_data_i,
    output logic [15:0] calib_o,
    output logic calib_valid_o,
    // status
    output logic debug_enable_o,
    output logic two_wire_debug_enable_o,
    output logic window_open_o,
    output logic startup_routine_req_o
);
    import dplw_pkg::*;

    ////////////////////////////////////////////////////////////////////
    function automatic logic is_key(input dplw_word_t w);
        is_key = (w == `DPLW_KEY);
    endfunction

    logic [`DPLW_CNT_W-1:0] cnt_reg;
    dplw_state_t state_reg;
    logic pwr_seen_reg;
    logic bor_flag_reg;
    logic suc_reg;
    logic [15:0] rdata_reg;
    logic lock_req;
    logic last_cycle;

    ////////////////////////////////////////////////////////////////////
    // cycle counter saturates at the window length
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= `DPLW_CNT_ZERO;
        end else if (cnt_reg != `DPLW_WINDOW_CYCLES) begin
            cnt_reg <= cnt_reg + `DPLW_CNT_ONE;
        end
    end

    assign window_open_o = (state_reg == DPLW_OPEN);
    // key and window end in one cycle: the key wins
    assign lock_req = (lock_wr_i && is_key(lock_wdata_i)) || low_power_i;
    assign last_cycle = (cnt_reg == `DPLW_WINDOW_CYCLES - `DPLW_CNT_ONE);

    // lock decision; key and low power only act while open
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= DPLW_OPEN;
        end else begin
            case (state_reg)
                DPLW_OPEN: begin
                    if (lock_req) begin
                        state_reg <= DPLW_LOCKED;
                    end else if (last_cycle) begin
                        state_reg <= DPLW_ENABLED;
                    end
                end
                DPLW_LOCKED: state_reg <= DPLW_LOCKED;
                DPLW_ENABLED: state_reg <= DPLW_ENABLED;
                default: state_reg <= DPLW_LOCKED;
            endcase
        end
    end

    assign debug_enable_o = (state_reg == DPLW_ENABLED);
    assign two_wire_debug_enable_o = (state_reg == DPLW_ENABLED);

    ////////////////////////////////////////////////////////////////////
    // read returns status only: bit0 high means debug disabled
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg <= `DPLW_RDATA_RST;
        end else if (lock_rd_i) begin
            rdata_reg <= {`DPLW_RDATA_PAD, state_reg != DPLW_ENABLED};
        end
    end
    assign lock_rdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // brownout flag: set by reset, cleared by firmware
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bor_flag_reg <= 1'b1;
        end else if (brownout_reset_flag_clr_i) begin
            bor_flag_reg <= 1'b0;
        end
    end
    assign brownout_reset_flag_o = bor_flag_reg;

    // startup request after any reset, including power up clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            suc_reg <= 1'b1;
            pwr_seen_reg <= 1'b0;
        end else begin
            suc_reg <= power_up_clear_i;
            pwr_seen_reg <= 1'b1;
        end
    end
    assign startup_routine_req_o = suc_reg | ~pwr_seen_reg;

    ////////////////////////////////////////////////////////////////////
    dplw_calib_hold u_calib (
        .clk_i(clk_i),
        .power_cycle_i(power_cycle_i),
        .load_i(calib_load_i),
        .load_data_i(calib_data_i),
        .calib_o(calib_o),
        .valid_o(calib_valid_o)
    );

    ////////////////////////////////////////////////////////////////////
    property p_late_write_ignored;
        @(posedge clk_i) disable iff (reset_i)
        !window_open_o |=> !window_open_o && $stable(debug_enable_o);
    endproperty
    a_late_write_ignored: assert property (p_late_write_ignored)
        else $error("lock state changed after window");

    property p_key_locks;
        @(posedge clk_i) disable iff (reset_i)
        // the release edge still sees the design in reset
        !reset_i && window_open_o && lock_wr_i &&
        lock_wdata_i == `DPLW_KEY
        |=> state_reg == DPLW_LOCKED && !debug_enable_o;
    endproperty
    a_key_locks: assert property (p_key_locks)
        else $error("key inside window did not lock");

    property p_auto_enable;
        @(posedge clk_i) disable iff (reset_i)
        window_open_o && !lock_wr_i && !low_power_i &&
        cnt_reg == `DPLW_WINDOW_CYCLES - `DPLW_CNT_ONE
        |=> debug_enable_o;
    endproperty
    a_auto_enable: assert property (p_auto_enable)
        else $error("debug not enabled at window end");

    property p_disabled_open;
        @(posedge clk_i) disable iff (reset_i)
        window_open_o |-> !debug_enable_o && !two_wire_debug_enable_o;
    endproperty
    a_disabled_open: assert property (p_disabled_open)
        else $error("debug enabled while window open");

    property p_low_power_locks;
        @(posedge clk_i) disable iff (reset_i)
        !reset_i && window_open_o && low_power_i
        |=> !two_wire_debug_enable_o [*8];
    endproperty
    a_low_power_locks: assert property (p_low_power_locks)
        else $error("low power in window did not lock");

    property p_read_status;
        @(posedge clk_i) disable iff (reset_i)
        lock_rd_i |=> lock_rdata_o[0] == !$past(debug_enable_o);
    endproperty
    a_read_status: assert property (p_read_status)
        else $error("read status wrong");

    property p_read_holds;
        @(posedge clk_i) disable iff (reset_i)
        !lock_rd_i |=> $stable(lock_rdata_o);
    endproperty
    a_read_holds: assert property (p_read_holds)
        else $error("read data changed without a read");

    property p_window_closes;
        @(posedge clk_i) disable iff (reset_i)
        cnt_reg == `DPLW_WINDOW_CYCLES |-> !window_open_o;
    endproperty
    a_window_closes: assert property (p_window_closes)
        else $error("window open past 64 cycles");

    property p_key_in_window;
        @(posedge clk_i) disable iff (reset_i)
        $rose(state_reg == DPLW_LOCKED) |-> $past(cnt_reg) < `DPLW_WINDOW_CYCLES;
    endproperty
    a_key_in_window: assert property (p_key_in_window)
        else $error("lock taken outside window");

    property p_suc_after_puc;
        @(posedge clk_i) disable iff (reset_i)
        power_up_clear_i |=> startup_routine_req_o;
    endproperty
    a_suc_after_puc: assert property (p_suc_after_puc)
        else $error("no startup request after clear");

    // warm resets must leave the calibration store alone
    property p_calib_kept;
        @(posedge clk_i) disable iff (power_cycle_i)
        !calib_load_i |=> $stable(calib_o) && $stable(calib_valid_o);
    endproperty
    a_calib_kept: assert property (p_calib_kept)
        else $error("calibration changed without a load");
endmodule
`default_nettype wire

/* tb/dplw_fw_model.sv */
// Purpose: start-up firmware model that drives the debug lock register
// Assumes: the first edge after reset release is cycle 0
// Notes: an idle data bus inverts its last value on every clock
`default_nettype none
module dplw_fw_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // decision
    input wire logic pw_match_i,
    input wire logic [7:0] at_i,
    input wire logic [15:0] data_i,
    // lock register port
    output logic lock_wr_o,
    output logic [15:0] lock_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_reg;
    logic go;
    // a matching password means no write at all
    assign go = !pw_match_i && (reset_i ? at_i == 8'h00
                                        : cnt_reg + 8'h01 == at_i);
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    // strobe and word move only on the clock, never on reset
    always_ff @(posedge clk_i) begin
        lock_wr_o <= go;
        lock_wdata_o <= go ? data_i : ~lock_wdata_o;
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the debug port lock window
// Assumes: edge n counts from reset release; outputs settle 1 ns after
// Notes: each run starts with a fresh reset of 21 cycles
`include "dplw_params.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, reset_i = 1, pc = 1, power_up_clear = 0, rd = 0, lp_i = 0;
    logic fclr = 0, cld = 0, fw_match = 1, wr, en, tw, win, su, flag, cv;
    logic [15:0] cdat = 16'h0000, fw_data = 16'h0000, wdat, rdat, cal;
    logic [7:0] fw_at = 8'hff;
    int err_total = 0, comparisons = 0, seed = 32'h25b6de68, r;
    logic [15:0] cal_exp;
    always #5 clk_i = ~clk_i;
    dplw_fw_model i_fw (.clk_i(clk_i), .reset_i(reset_i),
        .pw_match_i(fw_match), .at_i(fw_at), .data_i(fw_data),
        .lock_wr_o(wr), .lock_wdata_o(wdat));
    dplw_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .power_cycle_i(pc),
        .power_up_clear_i(power_up_clear), .lock_wr_i(wr), .lock_wdata_i(wdat),
        .lock_rd_i(rd), .lock_rdata_o(rdat), .low_power_i(lp_i),
        .brownout_reset_flag_clr_i(fclr), .brownout_reset_flag_o(flag),
        .calib_load_i(cld), .calib_data_i(cdat), .calib_o(cal),
        .calib_valid_o(cv), .debug_enable_o(en),
        .two_wire_debug_enable_o(tw), .window_open_o(win),
        .startup_routine_req_o(su));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // k: firmware write edge, d: its word, lp: low power edge (99 none)
    task automatic run(input logic [7:0] k, input logic [15:0] d,
                       input int lp);
        int lk, n;
        logic ld, ee;
        ld = (k == 8'hff) && (lp == 99);
        lk = (d == `DPLW_KEY && k < 64) ? k : 99;
        if (lp < 64 && lp < lk) lk = lp;
        @(posedge clk_i);
        reset_i <= 1;
        fw_at <= k;
        fw_data <= d;
        fw_match <= (k == 8'hff);
        repeat (20) @(posedge clk_i);
        #1 check(su, 1);
        check(flag, 1);
        check(rdat, 16'h0001);
        if (!ld) check(cv, 1);
        if (!ld) check(cal, cal_exp);
        @(posedge clk_i);
        reset_i <= 0;
        pc <= 0;
        lp_i <= (lp == 0);
        for (n = 0; n < 70; n++) begin
            @(posedge clk_i);
            r = $random(seed);
            cdat <= r[15:0];
            cld <= ld && n == 3;
            if (ld && n == 3) cal_exp = r[15:0];
            lp_i <= (n + 1 == lp);
            rd <= (n == 64);
            power_up_clear <= (n == 65);
            fclr <= (n == 66);
            // edge n ends cycle n + 1: edge 63 closes the window
            ee = (n + 1 >= 64) && (lk > 63);
            #1 check(en, ee);
            check(tw, ee);
            check(win, (n < lk) && (n + 1 < 64));
            if (n == 4 && ld) check(cal, cal_exp);
            if (n == 4 && ld) check(cv, 1);
            if (n == 20) check(su, 0);
            if (n == 65) check(rdat, {15'h0000, !ee});
            if (n == 66) check(su, 1);
            if (n == 67) check(flag, 0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        run(8'hff, 16'h0000, 99);
        run(8'h3f, `DPLW_KEY, 99);
        r = $random(seed);
        run({2'b00, r[5:0]}, `DPLW_KEY, 99);
        run(8'h40, `DPLW_KEY, 99);
        r = $random(seed);
        run(8'h05, (r[31:16] == `DPLW_KEY) ? 16'h0000 : r[31:16], 99);
        // checksum mismatch: firmware sleeps instead of calibrating
        run(8'hff, 16'h0000, 10);
        @(posedge clk_i);
        pc <= 1;
        @(posedge clk_i);
        #1 check(cv, 0);
        end_of_test();
    end
    // whole run is near 5500 ns; the limit leaves wide margin
    initial begin
        #20000;
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
